// ==== logic/fault_pkg.sv ====
package fault_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int MV_W = 16;
    localparam int CH_N = 2;
    localparam int AL_N = 4;
    localparam int DISP_W = 16;
    localparam int PRE_W = 26;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [PRE_W-1:0] BLINK_HALF_DEFAULT = PRE_W'(BLINK_HALF_CYC);
    localparam logic [PRE_W-1:0] PRE_ONE = 26'h0000001;
    localparam logic [PRE_W-1:0] PRE_ZERO = 26'h0000000;

    // ------------------------------------------------------------
    // Output levels and display codes
    // ------------------------------------------------------------
    // Current outputs are in 0.01 mA steps, others in 0.01 % steps.
    localparam logic [MV_W-1:0] CUR_OFF_CODE = 16'h00c8;
    localparam logic [MV_W-1:0] PCT_OFF_CODE = 16'h0000;
    // Display codes below are arbitrary symbol indices for the display driver.
    localparam logic [DISP_W-1:0] CODE_INPUT_ERR = 16'h0e01;
    localparam logic [DISP_W-1:0] CODE_MEM_ERR = 16'h0e02;
    localparam logic [DISP_W-1:0] CODE_ADC_ERR = 16'h0e03;
    localparam logic [DISP_W-1:0] CODE_ASSIGN_ERR = 16'h0e04;
    localparam logic [DISP_W-1:0] CODE_FATAL_ERR = 16'h0e05;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [MV_W-1:0] mv_t;

    typedef enum logic [1:0] {
        LAMP_OFF = 2'b00,
        LAMP_GREEN = 2'b01,
        LAMP_RED = 2'b10
    } lamp_color_e;

    typedef struct packed {
        logic green;
        logic red;
    } lamp_s;

    typedef struct packed {
        logic online;
        logic connected;
        logic comm_timeout;
        logic net_power_absent;
        logic dup_addr;
        logic bus_off;
    } net_status_s;

    typedef struct packed {
        logic fatal;
        logic assign_err;
        logic input_fault;
        logic mem_fault;
        logic adc_fault;
    } fault_s;

endpackage : fault_pkg

// ==== logic/blink_prescaler.sv ====
`timescale 1ns/1ps

module blink_prescaler import fault_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Half period in clock cycles, zero acts as one
    input wire logic [PRE_W-1:0] half_period,
    // Square wave phase, high in the lit half
    output logic blink_phase
);

    typedef struct packed {
        logic [PRE_W-1:0] cnt;
        logic phase;
    } pre_state_s;

    pre_state_s st_q;
    pre_state_s st_d;

    // Count up to the half period, then flip the phase.
    always_comb begin
        st_d = st_q;
        if (st_q.cnt + PRE_ONE >= half_period) begin
            st_d.cnt = PRE_ZERO;
            st_d.phase = ~st_q.phase;
        end else begin
            st_d.cnt = st_q.cnt + PRE_ONE;
        end
    end

    // Start lit so a blinking lamp shows at once after reset.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '{cnt: PRE_ZERO, phase: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    assign blink_phase = st_q.phase;

    // A half period of one, or of zero which acts as one, must flip the phase on every edge.
    chk_phase_flips: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE14
        (half_period <= PRE_ONE && $stable(half_period)) |=> (blink_phase != $past(blink_phase)))
        else $error("blink phase did not toggle at a one-cycle half period");

endmodule : blink_prescaler

// ==== logic/fault_status_indicator.sv ====
`timescale 1ns/1ps

// Overview of operation
// RULE1: Network and control healthy: both lamps steady green.
// RULE2: Node normal, no master connection yet: module green, network blinks green.
// RULE3: Master time-out or network power missing: network blinks red, module green.
// RULE4: Duplicate address or bus-off: network steady red, module green.
// RULE5: Fatal internal fault: module steady red, network off.
// RULE6: Data assignment error: module blinks red, network keeps its normal state.
// RULE7: Module lamp off while unpowered or held in reset.
// RULE8: Network lamp off whenever the node is not on-line.
// RULE9: Any active error alternates its code with the normal display item.
// RULE10: Input fault drives control outputs to the configured error value.
// RULE11: Input fault evaluates every alarm as upper limit exceeded.
// RULE12: Memory or converter fault: alarms off, control outputs forced off.
// RULE13: Memory and converter faults show distinct error codes.
// RULE14: Blinking and alternation use a prescaled counter with configurable period.
module fault_status_indicator import fault_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Conditions from the network engine and diagnostics, same clock
    input wire net_status_s net_status,
    input wire fault_s faults,
    // Blink half period in clock cycles
    input wire logic [PRE_W-1:0] blink_half_period,
    // Control path
    input wire mv_t [CH_N-1:0] computed_mv,
    input wire logic [CH_N-1:0] current_range,
    input wire mv_t mv_at_pv_error,
    // Alarm path
    input wire logic [AL_N-1:0] alarm_eval,
    input wire logic [AL_N-1:0] alarm_upper_eval,
    // Front display
    input wire logic [DISP_W-1:0] display_item,
    output logic [DISP_W-1:0] display_code,
    // Lamps
    output lamp_s module_status_lamp,
    output lamp_s network_status_lamp,
    // Process outputs
    output mv_t [CH_N-1:0] control_out,
    output logic [AL_N-1:0] alarm_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        lamp_s ms;
        lamp_s ns;
        logic [DISP_W-1:0] disp;
        mv_t [CH_N-1:0] ctrl;
        logic [AL_N-1:0] alarm;
    } ind_state_s;

    ind_state_s st_q;
    ind_state_s st_d;
    logic blink_phase;
    lamp_color_e ms_color;
    lamp_color_e ns_color;
    logic ms_blink;
    logic ns_blink;
    logic any_err;
    logic hard_fault;
    logic [DISP_W-1:0] err_code;

    // ------------------------------------------------------------
    // Blink timebase
    // ------------------------------------------------------------
    blink_prescaler u_blink (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .half_period(blink_half_period),
        .blink_phase(blink_phase)
    );

    // Turns a colour and a blink request into the lamp drive.
    function automatic lamp_s drive_lamp(lamp_color_e c, logic blink, logic phase);
        lamp_s l;
        l.green = (c == LAMP_GREEN) && (!blink || phase);
        l.red = (c == LAMP_RED) && (!blink || phase);
        return l;
    endfunction : drive_lamp

    // ------------------------------------------------------------
    // Lamp selection
    // ------------------------------------------------------------
    // Network conditions are ranked by severity; the fatal fault overrides all.
    always_comb begin
        ns_color = LAMP_GREEN; // see RULE1
        ns_blink = 1'b0;
        if (faults.fatal) begin
            ns_color = LAMP_OFF; // see RULE5
        end else if (!net_status.online) begin
            ns_color = LAMP_OFF; // see RULE8
        end else if (net_status.dup_addr || net_status.bus_off) begin
            ns_color = LAMP_RED; // see RULE4
        end else if (net_status.comm_timeout || net_status.net_power_absent) begin
            ns_color = LAMP_RED; // see RULE3
            ns_blink = 1'b1;
        end else if (!net_status.connected) begin
            ns_blink = 1'b1; // see RULE2
        end
    end

    // The assignment error leaves the network lamp to its own logic above.
    always_comb begin
        ms_color = LAMP_GREEN;
        ms_blink = 1'b0;
        if (faults.fatal) begin
            ms_color = LAMP_RED; // see RULE5
        end else if (faults.assign_err) begin
            ms_color = LAMP_RED; // see RULE6
            ms_blink = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Error code selection
    // ------------------------------------------------------------
    // Only one code fits the display, so the most severe one is shown.
    always_comb begin
        any_err = 1'b1;
        err_code = CODE_FATAL_ERR;
        if (faults.fatal) begin
            err_code = CODE_FATAL_ERR;
        end else if (faults.mem_fault) begin
            err_code = CODE_MEM_ERR; // see RULE13
        end else if (faults.adc_fault) begin
            err_code = CODE_ADC_ERR; // see RULE13
        end else if (faults.input_fault) begin
            err_code = CODE_INPUT_ERR;
        end else if (faults.assign_err) begin
            err_code = CODE_ASSIGN_ERR;
        end else begin
            any_err = 1'b0;
        end
    end

    assign hard_fault = faults.mem_fault || faults.adc_fault;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.ms = drive_lamp(ms_color, ms_blink, blink_phase); // see RULE14
        st_d.ns = drive_lamp(ns_color, ns_blink, blink_phase);
        // The error code takes the lit half, the normal item the dark half.
        st_d.disp = (any_err && blink_phase) ? err_code : display_item; // see RULE9
        for (int i = 0; i < CH_N; i++) begin
            if (hard_fault) begin
                st_d.ctrl[i] = current_range[i] ? CUR_OFF_CODE : PCT_OFF_CODE; // see RULE12
            end else if (faults.input_fault) begin
                st_d.ctrl[i] = mv_at_pv_error; // see RULE10
            end else begin
                st_d.ctrl[i] = computed_mv[i];
            end
        end
        if (hard_fault) begin
            st_d.alarm = '0; // see RULE12
        end else if (faults.input_fault) begin
            st_d.alarm = alarm_upper_eval; // see RULE11
        end else begin
            st_d.alarm = alarm_eval;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset darkens both lamps and clears every process output to zero, which is below the current off code.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0; // see RULE7
        end else begin
            st_q <= st_d;
        end
    end

    assign module_status_lamp = st_q.ms;
    assign network_status_lamp = st_q.ns;
    assign display_code = st_q.disp;
    assign control_out = st_q.ctrl;
    assign alarm_out = st_q.alarm;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_healthy_green: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE1
        (!faults.fatal && !faults.assign_err && net_status == 6'b110000)
        |=> (module_status_lamp == 2'b10 && network_status_lamp == 2'b10))
        else $error("healthy node does not show two steady green lamps");

    chk_unconnected_blink: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE2
        (!faults.fatal && net_status == 6'b100000)
        |=> (!network_status_lamp.red && network_status_lamp.green == $past(blink_phase)))
        else $error("network lamp does not blink green before connection");

    chk_timeout_red_blink: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE3
        (!faults.fatal && net_status.online && !net_status.dup_addr && !net_status.bus_off
        && (net_status.comm_timeout || net_status.net_power_absent))
        |=> (!network_status_lamp.green && network_status_lamp.red == $past(blink_phase)))
        else $error("network lamp does not blink red on time-out");

    chk_busoff_red: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE4
        (!faults.fatal && net_status.online && (net_status.dup_addr || net_status.bus_off))
        |=> (network_status_lamp == 2'b01))
        else $error("network lamp not steady red on bus-off");

    chk_fatal_lamps: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE5
        faults.fatal |=> (module_status_lamp == 2'b01 && network_status_lamp == 2'b00))
        else $error("fatal fault lamp pattern wrong");

    chk_assign_blink: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE6
        (!faults.fatal && faults.assign_err)
        |=> (!module_status_lamp.green && module_status_lamp.red == $past(blink_phase)))
        else $error("module lamp does not blink red on assignment error");

    chk_offline_dark: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE8
        !net_status.online |=> (network_status_lamp == 2'b00))
        else $error("network lamp lit while off-line");

    chk_display_alt: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE9
        (faults.mem_fault && !faults.fatal && blink_phase)
        ##1 (faults.mem_fault && !faults.fatal && !blink_phase)
        |-> (display_code == CODE_MEM_ERR) ##1 (display_code == $past(display_item)))
        else $error("display does not alternate code and item");

    chk_input_mv: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE10
        (faults.input_fault && !faults.mem_fault && !faults.adc_fault)
        |=> (control_out[0] == $past(mv_at_pv_error) && control_out[1] == $past(mv_at_pv_error)))
        else $error("control output ignores error manipulated value");

    chk_input_alarm: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE11
        (faults.input_fault && !faults.mem_fault && !faults.adc_fault)
        |=> (alarm_out == $past(alarm_upper_eval)))
        else $error("alarms not evaluated as upper limit exceeded");

    chk_hard_off: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE12
        (faults.mem_fault || faults.adc_fault) |=> (alarm_out == '0
        && control_out[0] == ($past(current_range[0]) ? CUR_OFF_CODE : PCT_OFF_CODE)))
        else $error("outputs not forced off on memory or converter fault");

    chk_adc_code: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE13
        (faults.adc_fault && !faults.mem_fault && !faults.fatal && blink_phase)
        |=> (display_code == CODE_ADC_ERR))
        else $error("converter fault code not shown");

endmodule : fault_status_indicator

// ==== test/net_master_model.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Network master seen from the node
// ------------------------------------------------------------
module net_master_model import fault_pkg::*; (
    // Scenario selection from the bench
    input wire logic [2:0] mode,
    // Status reported towards the node
    output net_status_s net_status
);

    // Modes 1 to 5 each raise one condition only and mode 6 drops both on-line and connected, so the lamp priority is seen one step at a time.
    // Modes 2 to 5 stay on-line and connected, so only their own condition can explain a lamp.
    always_comb begin
        net_status = '0;
        net_status.online = (mode != 3'h6);
        net_status.connected = (mode != 3'h1) && (mode != 3'h6);
        net_status.comm_timeout = (mode == 3'h2);
        net_status.net_power_absent = (mode == 3'h3);
        net_status.dup_addr = (mode == 3'h4);
        net_status.bus_off = (mode == 3'h5);
    end

endmodule : net_master_model

// ==== test/fault_status_indicator_tb.sv ====
`timescale 1ns/1ps

module fault_status_indicator_tb import fault_pkg::*; ;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam lamp_s GRN = 2'b10;
    localparam lamp_s RED = 2'b01;
    localparam lamp_s DARK = 2'b00;
    logic ref_clk;
    logic sys_rst;
    logic [2:0] mode;
    logic [PRE_W-1:0] blink_half;
    net_status_s net_status;
    fault_s faults;
    mv_t [CH_N-1:0] computed_mv;
    mv_t [CH_N-1:0] ctl_off;
    mv_t mv_at_pv_error;
    logic [AL_N-1:0] alarm_eval;
    logic [AL_N-1:0] alarm_upper_eval;
    logic [AL_N-1:0] alarm_out;
    logic [DISP_W-1:0] display_item;
    logic [DISP_W-1:0] display_code;
    lamp_s ms_lamp;
    lamp_s ns_lamp;
    mv_t [CH_N-1:0] control_out;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    net_master_model master (.mode(mode), .net_status(net_status));

    fault_status_indicator dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .net_status(net_status), .faults(faults),
        .blink_half_period(blink_half), .computed_mv(computed_mv),
        .current_range(2'h1), .mv_at_pv_error(mv_at_pv_error), .alarm_eval(alarm_eval),
        .alarm_upper_eval(alarm_upper_eval), .display_item(display_item),
        .display_code(display_code), .module_status_lamp(ms_lamp),
        .network_status_lamp(ns_lamp), .control_out(control_out), .alarm_out(alarm_out)
    );

    // Clock at 100 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // A hang ends the run as a failure instead of running for ever.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic set_in(input logic [2:0] m, input fault_s f);
        @(negedge ref_clk);
        mode = m;
        faults = f;
    endtask : set_in

    // Sixteen cycles cover a whole number of blink periods at every half period used (4, 2, 1, 0 as 1), so a blinking lamp is lit exactly 8 times
    // whatever the phase at the start; a steady lamp shows its colour all 16 times.
    task automatic watch(input lamp_s ms_e, input bit ms_b, input lamp_s ns_e, input bit ns_b,
            input logic [DISP_W-1:0] code_e, input bit alt, input mv_t [CH_N-1:0] ctl_e,
            input logic [AL_N-1:0] al_e);
        int ms_on = 0;
        int ms_off = 0;
        int ns_on = 0;
        int ns_off = 0;
        int d_code = 0;
        int d_item = 0;
        int bad = 0;
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            #1;
            ms_on += int'(ms_lamp === ms_e);
            ms_off += int'(ms_lamp === DARK && ms_e !== DARK);
            ns_on += int'(ns_lamp === ns_e);
            ns_off += int'(ns_lamp === DARK && ns_e !== DARK);
            d_code += int'(display_code === code_e);
            d_item += int'(display_code === display_item);
            bad += int'(control_out !== ctl_e || alarm_out !== al_e);
        end
        check(ms_on, ms_b ? 8 : 16, "module lamp lit count");
        check(ms_on + ms_off, 16, "module lamp colour");
        check(ns_on, ns_b ? 8 : 16, "network lamp lit count");
        check(ns_on + ns_off, 16, "network lamp colour");
        check(d_code, alt ? 8 : 0, "display code count");
        check(d_item, alt ? 8 : 16, "display item count");
        check(bad, 0, "process outputs");
    endtask : watch

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        @(negedge ref_clk);
        sys_rst = 1'b1;
        #1;
        check({ms_lamp, ns_lamp}, 4'h0, "lamps in reset");
        check(alarm_out, 4'h0, "alarms in reset");
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
    endtask : t_reset

    task automatic t_network();
        lamp_s ns_t[7] = '{GRN, GRN, RED, RED, RED, RED, DARK};
        bit nb_t[7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        for (int m = 0; m < 7; m++) begin
            set_in(3'(m), '0);
            watch(GRN, 0, ns_t[m], nb_t[m], 16'h0000, 0, computed_mv, alarm_eval);
        end
    endtask : t_network

    task automatic t_faults();
        set_in(3'h0, 5'h10);
        watch(RED, 0, DARK, 0, CODE_FATAL_ERR, 1, computed_mv, alarm_eval);
        set_in(3'h4, 5'h08);
        watch(RED, 1, RED, 0, CODE_ASSIGN_ERR, 1, computed_mv, alarm_eval);
        set_in(3'h0, 5'h04);
        watch(GRN, 0, GRN, 0, CODE_INPUT_ERR, 1, {2{mv_at_pv_error}}, alarm_upper_eval);
        set_in(3'h0, 5'h06);
        watch(GRN, 0, GRN, 0, CODE_MEM_ERR, 1, ctl_off, 4'h0);
        set_in(3'h0, 5'h05);
        watch(GRN, 0, GRN, 0, CODE_ADC_ERR, 1, ctl_off, 4'h0);
        set_in(3'h0, 5'h00);
        watch(GRN, 0, GRN, 0, 16'h0000, 0, computed_mv, alarm_eval);
    endtask : t_faults

    // Short half periods, zero included, must still give an even blink over sixteen cycles.
    task automatic t_blink();
        logic [PRE_W-1:0] hp_t[3] = '{26'h0000001, 26'h0000000, 26'h0000002};
        for (int k = 0; k < 3; k++) begin
            @(negedge ref_clk);
            blink_half = hp_t[k];
            set_in(3'h2, 5'h08);
            watch(RED, 1, RED, 1, CODE_ASSIGN_ERR, 1, computed_mv, alarm_eval);
        end
        @(negedge ref_clk);
        blink_half = 26'h0000004;
    endtask : t_blink

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        mode = 3'h0;
        blink_half = 26'h0000004;
        faults = '0;
        computed_mv = {16'h0321, 16'h0654};
        ctl_off = {PCT_OFF_CODE, CUR_OFF_CODE};
        mv_at_pv_error = 16'h0777;
        alarm_eval = 4'h5;
        alarm_upper_eval = 4'ha;
        display_item = 16'h1234;
        repeat (5) @(posedge ref_clk);
        #1;
        check({ms_lamp, ns_lamp}, 4'h0, "lamps after power-up reset");
        @(negedge ref_clk);
        sys_rst = 1'b0;
        t_network();
        t_faults();
        t_blink();
        t_reset();
        t_network();
        final_report();
    end

endmodule : fault_status_indicator_tb
